// ==== region_memory_protection_consts.vh ====
`ifndef REGION_MEMORY_PROTECTION_CONSTS_VH
`define REGION_MEMORY_PROTECTION_CONSTS_VH
// ==========================================================
// Register word indices; the byte address is four times the index.
`define RMP_CTRL_OFF      4'h0
`define RMP_COUNT_OFF     4'h1
`define RMP_SELECT_OFF    4'h2
`define RMP_BASE_OFF      4'h3
`define RMP_ATTR_OFF      4'h4
`define RMP_STATUS_OFF    4'h5
`define RMP_FADDR_OFF     4'h6
// ==========================================================
// Control register fields
`define RMP_CTRL_ENABLE   0
`define RMP_CTRL_PRIVDEF  1
`define RMP_CTRL_HFNMI    2
`define RMP_CTRL_FAULTEN  3
`define RMP_CTRL_RESET    4'h0
// ==========================================================
// Region attribute fields
`define RMP_ATTR_EN       0
`define RMP_ATTR_SIZE_LO  1
`define RMP_ATTR_SIZE_HI  5
`define RMP_ATTR_SRD_LO   8
`define RMP_ATTR_SRD_HI   15
`define RMP_ATTR_XN       16
`define RMP_ATTR_AP_LO    24
`define RMP_ATTR_AP_HI    26
`define RMP_ATTR_MASK     32'h0701FF3F
`define RMP_ATTR_RESET    32'h00000000
`define RMP_BASE_MASK     32'hFFFFFFE0
`define RMP_BASE_RESET    32'h00000000
// ==========================================================
// Size codes: region spans 2^(code+1) bytes
`define RMP_SIZE_MIN      5'h04
`define RMP_SIZE_SUBMIN   5'h07
// ==========================================================
// Access permission codes
`define RMP_AP_NONE       3'h0
`define RMP_AP_PRW_UNO    3'h1
`define RMP_AP_PRW_URO    3'h2
`define RMP_AP_PRW_URW    3'h3
`define RMP_AP_PRO_UNO    3'h5
`define RMP_AP_PRO_URO    3'h6
`define RMP_AP_PRO_URO2   3'h7
// ==========================================================
// Geometry and bus answers
`define RMP_REGIONS       8
`define RMP_REGION_COUNT  32'h00000008
`define RMP_RESP_OKAY     2'h0
`define RMP_RESP_SLVERR   2'h2
`endif

// ==== region_memory_protection.v ====
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`include "region_memory_protection_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module region_memory_protection (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        acc_valid,
  input  wire [31:0] acc_addr,
  input  wire        acc_fetch,
  input  wire        acc_write,
  input  wire        acc_priv,
  input  wire        acc_in_fault_handler,
  output reg         acc_violation,
  output reg         acc_default_map,
  output reg         mem_fault_exc
);

  // ==========================================================
  // Helper functions

  function [31:0] merge_bytes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer k;
    begin
      merge_bytes = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge_bytes[8*k +: 8] = new_val[8*k +: 8];
        end
      end
    end
  endfunction

  // Codes below the minimum behave as the 32-byte size.
  function [4:0] eff_size;
    input [31:0] attr;
    begin
      eff_size = attr[`RMP_ATTR_SIZE_HI:`RMP_ATTR_SIZE_LO];
      if (eff_size < `RMP_SIZE_MIN) begin
        eff_size = `RMP_SIZE_MIN;
      end
    end
  endfunction

  function region_hit;
    input [31:0] base;
    input [31:0] attr;
    input [31:0] addr;
    reg   [4:0]  sz;
    reg   [31:0] upper_mask;
    reg   [2:0]  sub_idx;
    reg   [31:0] shifted;
    begin
      sz = eff_size(attr);
      // Code 31 spans the whole space, so nothing above is compared.
      if (sz == 5'h1F) begin
        upper_mask = 32'h00000000;
      end else begin
        upper_mask = 32'hFFFFFFFF << (sz + 5'h01);
      end
      shifted = addr >> (sz - 5'h02);
      sub_idx = shifted[2:0];
      region_hit = attr[`RMP_ATTR_EN] && ((addr & upper_mask) == (base & upper_mask));
      if (sz >= `RMP_SIZE_SUBMIN && attr[`RMP_ATTR_SRD_LO + sub_idx]) begin
        region_hit = 1'b0;
      end
    end
  endfunction

  function ap_allows;
    input [2:0] ap;
    input       priv;
    input       write;
    begin
      case (ap)
        `RMP_AP_PRW_UNO:  ap_allows = priv;
        `RMP_AP_PRW_URO:  ap_allows = priv | ~write;
        `RMP_AP_PRW_URW:  ap_allows = 1'b1;
        `RMP_AP_PRO_UNO:  ap_allows = priv & ~write;
        `RMP_AP_PRO_URO:  ap_allows = ~write;
        `RMP_AP_PRO_URO2: ap_allows = ~write;
        default:          ap_allows = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // Register state

  reg [3:0]  ctrl_reg;
  reg [2:0]  select_reg;
  reg        status_reg;
  reg [31:0] faddr_reg;
  reg [31:0] base_reg [0:`RMP_REGIONS-1];
  reg [31:0] attr_reg [0:`RMP_REGIONS-1];

  reg        aw_held_reg;
  reg [31:0] aw_addr_reg;
  reg        w_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;

  wire       do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire [3:0] wr_idx   = aw_addr_reg[5:2];
  wire       wr_ok    = (aw_addr_reg[31:6] == 26'h0) && (wr_idx <= `RMP_FADDR_OFF);
  wire [3:0] rd_idx   = s_axi_araddr[5:2];
  wire       rd_ok    = (s_axi_araddr[31:6] == 26'h0) && (rd_idx <= `RMP_FADDR_OFF);
  // Unmapped writes steer to an unused index so that aliases above the map change nothing.
  wire [3:0]  wr_sel      = wr_ok ? wr_idx : 4'hF;
  wire [31:0] ctrl_merged = merge_bytes({28'h0, ctrl_reg}, w_data_reg, w_strb_reg);

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign s_axi_arready = !s_axi_rvalid;

  // ==========================================================
  // Access check

  reg        viol_next;
  reg        dflt_next;
  reg        any_hit;
  reg [2:0]  hit_idx;
  reg [31:0] hit_attr;
  integer    i;

  always @* begin
    any_hit  = 1'b0;
    hit_idx  = 3'h0;
    for (i = 0; i < `RMP_REGIONS; i = i + 1) begin
      if (region_hit(base_reg[i], attr_reg[i], acc_addr)) begin
        any_hit = 1'b1;
        hit_idx = i[2:0];
      end
    end
    hit_attr  = attr_reg[hit_idx];
    viol_next = 1'b0;
    dflt_next = 1'b0;
    if (!ctrl_reg[`RMP_CTRL_ENABLE]) begin
      dflt_next = 1'b1;
    end else if (acc_in_fault_handler && !ctrl_reg[`RMP_CTRL_HFNMI]) begin
      dflt_next = 1'b1;
    end else if (!any_hit) begin
      if (acc_priv && ctrl_reg[`RMP_CTRL_PRIVDEF]) begin
        dflt_next = 1'b1;
      end else begin
        viol_next = 1'b1;
      end
    end else if (acc_fetch && hit_attr[`RMP_ATTR_XN]) begin
      viol_next = 1'b1;
    end else if (!ap_allows(hit_attr[`RMP_ATTR_AP_HI:`RMP_ATTR_AP_LO],
                            acc_priv, acc_write & ~acc_fetch)) begin
      viol_next = 1'b1;
    end
  end

  // The verdict is registered so the wide compare tree never reaches the
  // core's exception logic in the same cycle.
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_violation   <= 1'b0;
      acc_default_map <= 1'b0;
      mem_fault_exc   <= 1'b0;
    end else begin
      acc_violation   <= acc_valid && viol_next;
      acc_default_map <= acc_valid && dflt_next;
      mem_fault_exc   <= acc_valid && viol_next && ctrl_reg[`RMP_CTRL_FAULTEN];
    end
  end

  // ==========================================================
  // Write channel and register updates

  integer r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= 32'h00000000;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RMP_RESP_OKAY;
      ctrl_reg     <= `RMP_CTRL_RESET;
      select_reg   <= 3'h0;
      status_reg   <= 1'b0;
      faddr_reg    <= 32'h00000000;
      for (r = 0; r < `RMP_REGIONS; r = r + 1) begin
        base_reg[r] <= `RMP_BASE_RESET;
        attr_reg[r] <= `RMP_ATTR_RESET;
      end
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RMP_RESP_OKAY : `RMP_RESP_SLVERR;
        case (wr_sel)
          `RMP_CTRL_OFF: begin
            ctrl_reg <= ctrl_merged[3:0];
          end
          `RMP_SELECT_OFF: begin
            if (w_strb_reg[0]) begin
              select_reg <= w_data_reg[2:0];
            end
          end
          `RMP_BASE_OFF: begin
            base_reg[select_reg] <= merge_bytes(base_reg[select_reg], w_data_reg,
                                                w_strb_reg) & `RMP_BASE_MASK;
          end
          `RMP_ATTR_OFF: begin
            // Enable lives in the attribute word, so base is untouched.
            attr_reg[select_reg] <= merge_bytes(attr_reg[select_reg], w_data_reg,
                                                w_strb_reg) & `RMP_ATTR_MASK;
          end
          `RMP_STATUS_OFF: begin
            if (w_strb_reg[0] && w_data_reg[0]) begin
              status_reg <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      // A new violation is placed after the clear so that it wins.
      if (acc_violation) begin
        status_reg <= 1'b1;
      end
      if (acc_valid && viol_next) begin
        faddr_reg <= acc_addr;
      end
    end
  end

  // ==========================================================
  // Read channel

  reg [31:0] rd_data;

  always @* begin
    case (rd_idx)
      `RMP_CTRL_OFF:   rd_data = {28'h0, ctrl_reg};
      `RMP_COUNT_OFF:  rd_data = `RMP_REGION_COUNT;
      `RMP_SELECT_OFF: rd_data = {29'h0, select_reg};
      `RMP_BASE_OFF:   rd_data = base_reg[select_reg];
      `RMP_ATTR_OFF:   rd_data = attr_reg[select_reg];
      `RMP_STATUS_OFF: rd_data = {31'h0, status_reg};
      `RMP_FADDR_OFF:  rd_data = faddr_reg;
      default:         rd_data = 32'h00000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RMP_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_ok ? rd_data : 32'h00000000;
      s_axi_rresp  <= rd_ok ? `RMP_RESP_OKAY : `RMP_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // region_memory_protection
`default_nettype wire

// ==== region_memory_protection_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module region_memory_protection_properties (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire acc_valid,
  input wire acc_violation,
  input wire acc_default_map,
  input wire mem_fault_exc
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ====================
  // Core verdicts
  chk_exc_viol: assert property (mem_fault_exc |-> acc_violation)
    else $error("fault exception without a violation");
  chk_idle_quiet: assert property (!acc_valid |=> !acc_violation && !acc_default_map)
    else $error("verdict without an access");
  chk_idle_exc: assert property (!acc_valid |=> !mem_fault_exc)
    else $error("fault exception without an access");
  chk_map_excl: assert property (acc_default_map |-> !acc_violation)
    else $error("default map access flagged as violation");
  // ====================
  // Register bus, then covers of the core verdicts
  chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after acceptance");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  chk_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after acceptance");
  cover property (acc_violation && mem_fault_exc);
  cover property (acc_violation && !mem_fault_exc);
  cover property (acc_default_map);
endmodule // region_memory_protection_properties
bind region_memory_protection region_memory_protection_properties props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .acc_valid(acc_valid),
  .acc_violation(acc_violation), .acc_default_map(acc_default_map),
  .mem_fault_exc(mem_fault_exc)
);
`default_nettype wire

// ==== core_access_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module core_access_model (
  input  wire         aclk,
  output logic        acc_valid,
  output logic [31:0] acc_addr,
  output logic        acc_fetch,
  output logic        acc_write,
  output logic        acc_priv,
  output logic        acc_in_fault_handler
);
  initial begin
    {acc_valid, acc_fetch, acc_write, acc_priv, acc_in_fault_handler} = 5'h00;
    acc_addr = 32'h0;
  end
  // Kind is {fetch, write, privileged, in handler}; calls back to back give one access a cycle.
  task automatic issue(input logic [31:0] a, input logic [3:0] k);
    @(posedge aclk);
    acc_valid <= 1'b1;
    acc_addr <= a;
    {acc_fetch, acc_write, acc_priv, acc_in_fault_handler} <= k;
  endtask
  // Idle bus shows the inverted address so a stale value is never mistaken for a live one.
  task automatic rest;
    @(posedge aclk);
    acc_valid <= 1'b0;
    acc_addr <= ~acc_addr;
  endtask
endmodule // core_access_model
`default_nettype wire

// ==== tb.sv ====
`include "region_memory_protection_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam [31:0] ctrl_a = `RMP_CTRL_OFF * 4;
  localparam [31:0] cnt_a  = `RMP_COUNT_OFF * 4;
  localparam [31:0] sel_a  = `RMP_SELECT_OFF * 4;
  localparam [31:0] base_a = `RMP_BASE_OFF * 4;
  localparam [31:0] attr_a = `RMP_ATTR_OFF * 4;
  localparam [1:0]  ok     = `RMP_RESP_OKAY;
  logic        aclk = 1'b0, aresetn = 1'b0, vld_d = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, a_addr;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, a_vld, a_f, a_w, a_p, a_h, viol, dmap, exc;
  logic [1:0]  bresp, rresp;
  logic [33:0] bq[$], rq[$], cq[$];
  int          err_total = 0, check_count = 0, i;
  always #2 aclk = ~aclk;
  region_memory_protection dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .acc_valid(a_vld), .acc_addr(a_addr), .acc_fetch(a_f), .acc_write(a_w), .acc_priv(a_p),
    .acc_in_fault_handler(a_h), .acc_violation(viol), .acc_default_map(dmap),
    .mem_fault_exc(exc));
  core_access_model core (.aclk(aclk), .acc_valid(a_vld), .acc_addr(a_addr), .acc_fetch(a_f),
    .acc_write(a_w), .acc_priv(a_p), .acc_in_fault_handler(a_h));
  // ====================
  // Tasks
  task automatic cmp(input logic [33:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: expected %h, got %h", $time, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
    logic pa, pw;
    bq.push_back({32'h0, r});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      pa = awvalid && awready;
      pw = wvalid && wready;
      @(posedge aclk);
      if (pa) awvalid <= 1'b0;
      if (pw) wvalid <= 1'b0;
    end while ((awvalid && !pa) || (wvalid && !pw));
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // Expected verdict e is {violation, default map, fault exception}.
  task automatic acc(input logic [31:0] a, input logic [3:0] k, input logic [2:0] e);
    cq.push_back({31'h0, e});
    core.issue(a, k);
  endtask
  task automatic cfg(input logic [31:0] n, b, t);
    wr(sel_a, n, ok);
    wr(base_a, b, ok);
    wr(attr_a, t, ok);
    rd(base_a, {ok, b});
    rd(attr_a, {ok, t});
  endtask
  // ====================
  // Output watcher
  always @(posedge aclk) vld_d <= a_vld;
  always @(negedge aclk) begin
    if (bvalid && bready) cmp(bq.pop_front(), {32'h0, bresp});
    if (rvalid && rready) cmp(rq.pop_front(), {rresp, rdata});
    if (vld_d) cmp(cq.pop_front(), {31'h0, viol, dmap, exc});
  end
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    complete_run;
  end
  // ====================
  // Scenarios
  initial begin
    void'($urandom(32'hD347));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(cnt_a, {ok, `RMP_REGION_COUNT});
    wr(32'h40, 32'hF, `RMP_RESP_SLVERR);
    rd(ctrl_a, 34'h0);
    rd(32'h1C, {`RMP_RESP_SLVERR, 32'h0});
    wr(32'h20, 32'hFFFFFFFF, `RMP_RESP_SLVERR);
    acc(32'h2000_0000, 4'h4, 3'b010);
    core.rest;
    // Regions are set up while protection is off, so no access sees half a setup.
    cfg(0, 32'h2000_0000, 32'h0301_0413);
    cfg(2, 32'h3000_0000, 32'h0500_0009);
    cfg(1, 32'h2000_0000, 32'h0600_FF09);
    wr(ctrl_a, 32'h9, ok);
    acc(32'h2000_0000, 4'h4, 3'b101);
    acc(32'h2000_0004, 4'h0, 3'b000);
    acc(32'h2000_0100, 4'h0, 3'b101);
    acc(32'h2000_0080, 4'h8, 3'b101);
    acc(32'h2000_0200, 4'h4, 3'b000);
    acc(32'h4000_0000, 4'h2, 3'b101);
    acc(32'h4000_0000, 4'h1, 3'b010);
    acc(32'h3000_0000, 4'h2, 3'b000);
    acc(32'h3000_0004, 4'h6, 3'b101);
    acc(32'h3000_0008, 4'h0, 3'b101);
    for (i = 0; i < 8; i++) acc(32'h2000_0200 | ($urandom & 32'h1FC), 4'h6, 3'b000);
    core.rest;
    wr(ctrl_a, 32'hF, ok);
    acc(32'h4000_0000, 4'h2, 3'b010);
    acc(32'h4000_0000, 4'h0, 3'b101);
    acc(32'h4000_0000, 4'h1, 3'b101);
    core.rest;
    wr(ctrl_a, 32'h1, ok);
    acc(32'h2000_0000, 4'h4, 3'b100);
    core.rest;
    rd(`RMP_FADDR_OFF * 4, {ok, 32'h2000_0000});
    rd(`RMP_STATUS_OFF * 4, {ok, 32'h1});
    wr(`RMP_STATUS_OFF * 4, 32'h1, ok);
    rd(`RMP_STATUS_OFF * 4, {ok, 32'h0});
    wr(attr_a, 32'h0600_FF08, ok);
    acc(32'h2000_0000, 4'h4, 3'b000);
    core.rest;
    wr(attr_a, 32'h0600_FF09, ok);
    acc(32'h2000_0000, 4'h4, 3'b100);
    core.rest;
    wr(sel_a, 32'h0, ok);
    rd(attr_a, {ok, 32'h0301_0413});
    wr(ctrl_a, 32'h0, ok);
    acc(32'h2000_0100, 4'h4, 3'b010);
    core.rest;
    repeat (4) @(posedge aclk);
    complete_run;
  end
endmodule // tb
`default_nettype wire
